// *** inc/sbg_defines.vh ***
`ifndef SBG_DEFINES_VH
`define SBG_DEFINES_VH

// register byte offsets
`define SBG_OFF_RELOAD 8'h00
`define SBG_OFF_COUNT 8'h04
`define SBG_OFF_CONFIG 8'h08
`define SBG_OFF_CONTROL 8'h0c
`define SBG_OFF_COUNT_HI 8'h10

// reset values
`define SBG_RST_RELOAD 8'h00
`define SBG_RST_COUNT 8'h00
`define SBG_RST_CONFIG 8'h20
`define SBG_RST_CONTROL 8'h00

// config register fields
`define SBG_CFG_MODE_B3 7
`define SBG_CFG_M02_RATE 6
`define SBG_CFG_WIDTH 5
`define SBG_CFG_RUN 4
`define SBG_CFG_DOUBLE 3
`define SBG_CFG_SRC 2
`define SBG_CFG_CKOE 1
`define SBG_CFG_TME 0

// control register fields
`define SBG_CTL_MODE_B0 7
`define SBG_CTL_MODE_B1 6
`define SBG_CTL_ADDR_MATCH 5
`define SBG_CTL_RX_EN 4
`define SBG_CTL_TX_B8 3
`define SBG_CTL_RX_B8 2
`define SBG_CTL_TX_FLAG 1
`define SBG_CTL_RX_FLAG 0

// serial modes
`define SBG_MODE_SHIFT 3'h0
`define SBG_MODE_UART8 3'h1
`define SBG_MODE_UART9F 3'h2
`define SBG_MODE_UART9V 3'h3
`define SBG_MODE_SPI 3'h4

// divisors in system clocks, and the last oversample index of a bit
`define SBG_PRESCALE 4'hc
`define SBG_DIV_M0_SLOW 8'h0c
`define SBG_DIV_M0_FAST 8'h04
`define SBG_DIV_M2_LOW 8'h40
`define SBG_DIV_M2_LOW_X2 8'h20
`define SBG_DIV_M2_HIGH 8'hc0
`define SBG_DIV_M2_HIGH_X2 8'h60
`define SBG_OVERSAMPLE 4'hf

// axi responses
`define SBG_RESP_OKAY 2'h0
`define SBG_RESP_SLVERR 2'h2

`endif

// *** verilog/sbg_rate_generator.v ***
// Operation
// - 8-bit up-counter reloads from the 8-bit reload register on overflow.
// - overflow is the serial engine time base in modes 1 and 3.
// - while stopped, writing the reload register also loads the counter.
// - while running, reload writes leave the counter alone.
// - counter writes never touch the reload register.
// - clock output toggles on each overflow, half the overflow rate.
// - overflow pulse always feeds other peripherals, serial engine idle or not.
// - mode 0 rate is system clock over 12, or over 4 with source bit set.
// - mode 2 rate is clock times 2^double over 64, or over 192.
// - modes 1 and 3 rate follows 2^double/32 of clock/(12 or 1)/(256-reload).
// - timer mode disables serial; overflow sets the transmit flag.
// - timer mode: receive flag detects pin changes; ninth bit and enable gate irqs.
// - receive flag sets on falling edge if ninth bit 0 and enabled, on rising edge if ninth bit 1.
// - in power-down the pin detector is level-sensitive and wakes the processor.
// - timer mode may count timer 1 overflows, forming a cascaded timer.
// - clock-out enable drives the toggle clock onto the pin and masks receive irq.
// - counter counts system clock over 12 or undivided clock per source select.
// - clock out equals system clock over n*(256-reload), n is 24 or 2.
// - in timer mode the width bit picks 8-bit reload or 16-bit counting.
// - run bit clear stops the counter, set starts counting.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "sbg_defines.vh"

module sbg_rate_generator (
  input wire core_clk_i,
  input wire reset_i,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire receive_pin_i,
  input wire timer1_overflow_i,
  input wire power_down_i,
  input wire port_irq_enable_i,
  output reg generator_overflow_pulse_o,
  output reg generator_clock_out_o,
  output wire clock_out_oe_o,
  output reg serial_sample_tick_o,
  output reg serial_bit_tick_o,
  output reg serial_enable_o,
  output reg port_irq_o,
  output reg wake_o
);

  reg [7:0] baud_reload_value_r;
  reg [7:0] baud_counter_value_r;
  reg [7:0] count_hi_r;
  reg [7:0] port_config_reg_r;
  reg [7:0] port_control_reg_r;
  reg [3:0] presc_r;
  reg presc_tick_r;
  reg rx_meta_r;
  reg rx_sync_r;
  reg rx_prev_r;
  reg half_r;
  reg [3:0] sample_cnt_r;
  reg [7:0] rate_cnt_r;
  reg aw_full_r;
  reg w_full_r;
  reg [7:0] aw_addr_r;
  reg [7:0] w_data_r;
  reg w_lane0_r;

  wire timer_mode = port_config_reg_r[`SBG_CFG_TME];
  wire run = port_config_reg_r[`SBG_CFG_RUN];
  wire src_fast = port_config_reg_r[`SBG_CFG_SRC];
  wire dbl = port_config_reg_r[`SBG_CFG_DOUBLE];
  wire cko_en = port_config_reg_r[`SBG_CFG_CKOE];
  wire wide = port_config_reg_r[`SBG_CFG_WIDTH];
  wire addr_match = port_control_reg_r[`SBG_CTL_ADDR_MATCH];
  wire rx_en = port_control_reg_r[`SBG_CTL_RX_EN];
  wire tx_b8 = port_control_reg_r[`SBG_CTL_TX_B8];
  wire rx_b8 = port_control_reg_r[`SBG_CTL_RX_B8];
  wire [2:0] mode = {port_config_reg_r[`SBG_CFG_MODE_B3],
                     port_control_reg_r[`SBG_CTL_MODE_B0],
                     port_control_reg_r[`SBG_CTL_MODE_B1]};

  // ---------------- register bus ----------------
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_full_r & w_full_r;
  wire wr_lane = do_write & w_lane0_r;
  wire wr_reload = wr_lane & (aw_addr_r == `SBG_OFF_RELOAD);
  wire wr_count = wr_lane & (aw_addr_r == `SBG_OFF_COUNT);
  wire wr_config = wr_lane & (aw_addr_r == `SBG_OFF_CONFIG);
  wire wr_control = wr_lane & (aw_addr_r == `SBG_OFF_CONTROL);
  wire wr_count_hi = wr_lane & (aw_addr_r == `SBG_OFF_COUNT_HI);
  // a write with lane 0 off is still answered, but stores nothing
  reg wr_mapped;
  always @* begin
    case (aw_addr_r)
      `SBG_OFF_RELOAD, `SBG_OFF_COUNT, `SBG_OFF_CONFIG: wr_mapped = 1'b1;
      `SBG_OFF_CONTROL, `SBG_OFF_COUNT_HI: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // address and data may arrive in either order; each is held until both are in
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [7:0] rd_byte;
  reg rd_ok;
  always @* begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SBG_OFF_RELOAD: rd_byte = baud_reload_value_r;
      `SBG_OFF_COUNT: rd_byte = baud_counter_value_r;
      `SBG_OFF_CONFIG: rd_byte = port_config_reg_r;
      `SBG_OFF_CONTROL: rd_byte = port_control_reg_r;
      `SBG_OFF_COUNT_HI: rd_byte = count_hi_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SBG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_ok ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- counting ----------------
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      presc_r <= 4'h0;
      presc_tick_r <= 1'b0;
    end else begin
      presc_tick_r <= (presc_r == `SBG_PRESCALE - 4'h1);
      if (presc_r == `SBG_PRESCALE - 4'h1) begin
        presc_r <= 4'h0;
      end else begin
        presc_r <= presc_r + 4'h1;
      end
    end
  end

  // timer 1 cascade only in timer mode with the slow source and address-match bit
  wire cascade = timer_mode & ~src_fast & addr_match;
  reg count_tick;
  always @* begin
    if (cascade) begin
      count_tick = timer1_overflow_i;
    end else if (src_fast) begin
      count_tick = 1'b1;
    end else begin
      // the prescaler runs free, so the first slow tick after a start comes early
      count_tick = presc_tick_r;
    end
  end
  wire step = run & count_tick;
  // the high byte has no reload: 16-bit mode always counts the full range
  wire mode16 = timer_mode & wide;
  wire lo_wrap = step & (baud_counter_value_r == 8'hff);
  wire overflow = lo_wrap & (~mode16 | (count_hi_r == 8'hff));

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      baud_reload_value_r <= `SBG_RST_RELOAD;
      baud_counter_value_r <= `SBG_RST_COUNT;
      count_hi_r <= `SBG_RST_COUNT;
    end else begin
      if (wr_reload) begin
        baud_reload_value_r <= w_data_r;
      end
      // software access wins over a count edge in the same cycle
      if (wr_count) begin
        baud_counter_value_r <= w_data_r;
      end else if (wr_reload && !run) begin
        baud_counter_value_r <= w_data_r;
      end else if (lo_wrap && !mode16) begin
        baud_counter_value_r <= baud_reload_value_r;
      end else if (step) begin
        baud_counter_value_r <= baud_counter_value_r + 8'h01;
      end
      if (wr_count_hi) begin
        count_hi_r <= w_data_r;
      end else if (lo_wrap && mode16) begin
        count_hi_r <= count_hi_r + 8'h01;
      end
    end
  end

  // overflow goes out in every mode, serial engine idle or not
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      generator_overflow_pulse_o <= 1'b0;
      generator_clock_out_o <= 1'b0;
    end else begin
      generator_overflow_pulse_o <= overflow;
      if (overflow) begin
        generator_clock_out_o <= ~generator_clock_out_o;
      end
    end
  end

  // the pin mux outside takes the toggle output only while this enable is high
  assign clock_out_oe_o = cko_en;

  // ---------------- serial rate ticks ----------------
  wire var_mode = (mode == `SBG_MODE_UART8) | (mode == `SBG_MODE_UART9V);
  // without double rate every other overflow is an oversample tick: 2^dbl/32 overall
  wire sample_tick = overflow & (dbl | half_r);

  reg [7:0] div_limit;
  always @* begin
    div_limit = `SBG_DIV_M0_SLOW;
    case (mode)
      `SBG_MODE_SHIFT, `SBG_MODE_SPI:
        div_limit = src_fast ? `SBG_DIV_M0_FAST : `SBG_DIV_M0_SLOW;
      `SBG_MODE_UART9F: begin
        if (port_config_reg_r[`SBG_CFG_M02_RATE]) begin
          div_limit = dbl ? `SBG_DIV_M2_HIGH_X2 : `SBG_DIV_M2_HIGH;
        end else begin
          div_limit = dbl ? `SBG_DIV_M2_LOW_X2 : `SBG_DIV_M2_LOW;
        end
      end
      // reserved modes fall back to the slow fixed rate instead of stopping
      default: div_limit = `SBG_DIV_M0_SLOW;
    endcase
  end

  wire fixed_tick = (rate_cnt_r >= div_limit - 8'h01);

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      half_r <= 1'b0;
      sample_cnt_r <= 4'h0;
      rate_cnt_r <= 8'h00;
      serial_sample_tick_o <= 1'b0;
      serial_bit_tick_o <= 1'b0;
      serial_enable_o <= 1'b0;
    end else begin
      serial_enable_o <= ~timer_mode;
      if (overflow) begin
        half_r <= ~half_r;
      end
      if (fixed_tick || var_mode || timer_mode) begin
        rate_cnt_r <= 8'h00;
      end else begin
        rate_cnt_r <= rate_cnt_r + 8'h01;
      end
      if (timer_mode) begin
        sample_cnt_r <= 4'h0;
        serial_sample_tick_o <= 1'b0;
        serial_bit_tick_o <= 1'b0;
      end else if (var_mode) begin
        serial_sample_tick_o <= sample_tick;
        if (sample_tick) begin
          sample_cnt_r <= sample_cnt_r + 4'h1;
        end
        serial_bit_tick_o <= sample_tick & (sample_cnt_r == `SBG_OVERSAMPLE);
      end else begin
        sample_cnt_r <= 4'h0;
        serial_sample_tick_o <= fixed_tick;
        serial_bit_tick_o <= fixed_tick;
      end
    end
  end

  // ---------------- receive pin detector ----------------
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= receive_pin_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  wire rx_fall = rx_prev_r & ~rx_sync_r;
  wire rx_rise = ~rx_prev_r & rx_sync_r;
  wire rx_level_hit = rx_b8 ? rx_sync_r : ~rx_sync_r;
  wire rx_edge_hit = rx_b8 ? rx_rise : (rx_en & rx_fall);
  // in power-down the level detector keeps setting the flag while the pin stays active
  wire rx_hit = power_down_i ? (rx_en & rx_level_hit) : rx_edge_hit;
  wire tx_set = timer_mode & overflow;
  wire rx_set = timer_mode & rx_hit;

  // flags: hardware set wins over a software clear in the same cycle
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      port_config_reg_r <= `SBG_RST_CONFIG;
      port_control_reg_r <= `SBG_RST_CONTROL;
    end else begin
      if (wr_config) begin
        port_config_reg_r <= w_data_r;
      end
      if (wr_control) begin
        port_control_reg_r <= w_data_r;
      end
      if (tx_set) begin
        port_control_reg_r[`SBG_CTL_TX_FLAG] <= 1'b1;
      end
      if (rx_set) begin
        port_control_reg_r[`SBG_CTL_RX_FLAG] <= 1'b1;
      end
    end
  end

  wire tx_flag = port_control_reg_r[`SBG_CTL_TX_FLAG];
  wire rx_flag = port_control_reg_r[`SBG_CTL_RX_FLAG];
  wire irq_timer = (tx_flag & tx_b8) | (rx_flag & rx_en & ~cko_en);
  wire irq_any = timer_mode ? irq_timer : (tx_flag | (rx_flag & ~cko_en));

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      port_irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      port_irq_o <= irq_any;
      wake_o <= power_down_i & port_irq_enable_i & irq_any;
    end
  end

endmodule

// *** tb/sbg_properties.sv ***
`timescale 1ns/10ps
module sbg_properties (
  input wire core_clk_i,
  input wire reset_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire power_down_i,
  input wire port_irq_enable_i,
  input wire generator_overflow_pulse_o,
  input wire generator_clock_out_o,
  input wire clock_out_oe_o,
  input wire wake_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  AST_CKO_TOGGLE: assert property (generator_overflow_pulse_o |-> ##[0:1]
    $changed(generator_clock_out_o)) else $error("clock out missed a toggle");
  AST_CKO_ONLY: assert property ($changed(generator_clock_out_o) |->
    generator_overflow_pulse_o || $past(generator_overflow_pulse_o))
    else $error("clock out moved without overflow");
  AST_CKO_RESET: assert property ($fell(reset_i) |-> !generator_clock_out_o)
    else $error("clock out not low after reset");
  AST_OE_WRITE: assert property ($changed(clock_out_oe_o) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin enable moved without a write");
  AST_WRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_BONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_NO_AR: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_WAKE: assert property (wake_o |-> $past(power_down_i) && $past(port_irq_enable_i))
    else $error("wake without power-down and enable");
endmodule

bind sbg_rate_generator sbg_properties u_sbg_properties (.core_clk_i, .reset_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .power_down_i, .port_irq_enable_i, .generator_overflow_pulse_o,
  .generator_clock_out_o, .clock_out_oe_o, .wake_o);

// *** tb/sbg_serial_partner.sv ***
`timescale 1ns/10ps
module sbg_serial_partner (
  input wire core_clk_i,
  input wire reset_i,
  input wire ovf_i,
  input wire sample_i,
  input wire bit_i,
  output int ovf_cnt_o,
  output int spb_o
);
  int s;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ovf_cnt_o <= 0;
      s <= 0;
      spb_o <= 0;
    end else begin
      if (ovf_i) ovf_cnt_o <= ovf_cnt_o + 1;
      // a bit edge closes the count, the sample on the same edge included
      if (bit_i) begin
        spb_o <= s + sample_i;
        s <= 0;
      end else if (sample_i) s <= s + 1;
    end
  end
endmodule

// *** tb/sbg_rate_generator_bench.sv ***
`timescale 1ns/10ps
`include "sbg_defines.vh"
module sbg_rate_generator_bench;
  logic core_clk_i, reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, receive_pin_i, timer1_overflow_i, power_down_i, port_irq_enable_i;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic generator_overflow_pulse_o, generator_clock_out_o, clock_out_oe_o, serial_sample_tick_o;
  logic serial_bit_tick_o, serial_enable_o, port_irq_o, wake_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rv, cv;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  localparam logic [1:0] ok = `SBG_RESP_OKAY;
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [15:0] mt[8] = '{16'h0030, 16'h0034, 16'h8030, 16'h8038, 16'h8070, 16'h8078,
    16'h4034, 16'hc03c};
  int mg[8] = '{12, 4, 64, 32, 192, 96, 128, 64};
  int miscompares = 0, tests_run = 0, cyc = 0, t_ovf = 0, t_bit = 0, ovf_cnt, spb;
  logic [65:0] q[$], e;
  int oq[$], bq[$];
  int cq[$], t_ck = 0, n;
  logic ck_d = 1'b0, t1_rand = 1'b1, t1_drv = 1'b0;
  logic [15:0] v;
  wire ck_rise = generator_clock_out_o & ~ck_d;
  sbg_rate_generator u_sbg_rate_generator (.core_clk_i, .reset_i, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .receive_pin_i, .timer1_overflow_i, .power_down_i,
    .port_irq_enable_i, .generator_overflow_pulse_o, .generator_clock_out_o, .clock_out_oe_o,
    .serial_sample_tick_o, .serial_bit_tick_o, .serial_enable_o, .port_irq_o, .wake_o);
  sbg_serial_partner u_sbg_serial_partner (.core_clk_i, .reset_i,
    .ovf_i(generator_overflow_pulse_o), .sample_i(serial_sample_tick_o),
    .bit_i(serial_bit_tick_o), .ovf_cnt_o(ovf_cnt), .spb_o(spb));
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (x !== g) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    q.push_back({er, 64'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] d, input logic [31:0] m);
    q.push_back({er, d, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task wait_ev(input int b);
    do @(posedge core_clk_i);
    while (!(b == 2 ? ck_rise : b == 1 ? serial_bit_tick_o : generator_overflow_pulse_o));
  endtask
  // the first interval after a change is partial, so two events pass before the note
  task gap(input int b, input int g);
    wait_ev(b);
    wait_ev(b);
    @(posedge core_clk_i);
    if (b == 2) cq.push_back(g);
    else if (b == 1) bq.push_back(g);
    else oq.push_back(g);
    wait_ev(b);
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    timer1_overflow_i <= t1_rand ? 1'($urandom_range(1)) : t1_drv;
    ck_d <= generator_clock_out_o;
    if (ck_rise) begin
      if (cq.size() > 0) chk("clock out period", cq.pop_front(), cyc - t_ck);
      t_ck <= cyc;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      chk("bresp", {30'h0, e[65:64]}, {30'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk("rresp", {30'h0, e[65:64]}, {30'h0, s_axi_rresp});
      chk("rdata", e[63:32] & e[31:0], s_axi_rdata & e[31:0]);
    end
    if (generator_overflow_pulse_o) begin
      if (oq.size() > 0) chk("overflow gap", oq.pop_front(), cyc - t_ovf);
      t_ovf <= cyc;
    end
    if (serial_bit_tick_o) begin
      if (bq.size() > 0) chk("bit gap", bq.pop_front(), cyc - t_bit);
      t_bit <= cyc;
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    miscompares++;
    print_verdict;
  end
  initial begin
    void'($urandom(18));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {timer1_overflow_i, power_down_i, port_irq_enable_i} = 3'h0;
    receive_pin_i = 1'b1;
    reset_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ra[i], ok, i == 2 ? `SBG_RST_CONFIG : 32'h0, '1);
    wr(8'h14, 8'h5a, `SBG_RESP_SLVERR);
    rd(8'h14, `SBG_RESP_SLVERR, 32'h0, '1);
    $display("reset and map test done");
    rv = 8'($urandom);
    cv = 8'($urandom);
    wr(`SBG_OFF_RELOAD, rv, ok);
    rd(`SBG_OFF_COUNT, ok, {24'h0, rv}, '1);
    wr(`SBG_OFF_COUNT, cv, ok);
    rd(`SBG_OFF_RELOAD, ok, {24'h0, rv}, '1);
    repeat (30) @(posedge core_clk_i);
    rd(`SBG_OFF_COUNT, ok, {24'h0, cv}, '1);
    $display("register load test done");
    wr(`SBG_OFF_RELOAD, 8'hf0, ok);
    wr(`SBG_OFF_CONFIG, 8'h30, ok);
    wr(`SBG_OFF_RELOAD, 8'h10, ok);
    rd(`SBG_OFF_COUNT, ok, 32'hf0, 32'hf0);
    gap(0, 2880);
    wr(`SBG_OFF_CONFIG, 8'h34, ok);
    gap(0, 240);
    $display("counter test done");
    wr(`SBG_OFF_RELOAD, 8'hfc, ok);
    for (int i = 0; i < 8; i++) begin
      wr(`SBG_OFF_CONTROL, mt[i][15:8], ok);
      wr(`SBG_OFF_CONFIG, mt[i][7:0], ok);
      gap(1, mg[i]);
    end
    chk("samples per bit", 32'd16, spb);
    $display("bit rate test done");
    wr(`SBG_OFF_CONTROL, 8'h00, ok);
    wr(`SBG_OFF_CONFIG, 8'h15, ok);
    wait_ev(0);
    @(posedge core_clk_i);
    chk("serial enable", 32'h0, {31'h0, serial_enable_o});
    rd(`SBG_OFF_CONTROL, ok, 32'h02, 32'h02);
    wr(`SBG_OFF_CONTROL, 8'h10, ok);
    receive_pin_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rd(`SBG_OFF_CONTROL, ok, 32'h01, 32'h01);
    chk("port irq", 32'h1, {31'h0, port_irq_o});
    power_down_i <= 1'b1;
    port_irq_enable_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk("wake", 32'h1, {31'h0, wake_o});
    wr(`SBG_OFF_CONFIG, 8'h17, ok);
    repeat (3) @(posedge core_clk_i);
    chk("irq masked", 32'h0, {31'h0, port_irq_o});
    chk("pin enable", 32'h1, {31'h0, clock_out_oe_o});
    chk("overflow feed", 32'h1, {31'h0, ovf_cnt > 0});
    $display("timer mode test done");
    wr(`SBG_OFF_CONTROL, 8'h20, ok);
    wr(`SBG_OFF_CONFIG, 8'h21, ok);
    wr(`SBG_OFF_COUNT, 8'hfe, ok);
    wr(`SBG_OFF_COUNT_HI, 8'h12, ok);
    t1_rand <= 1'b0;
    wr(`SBG_OFF_CONFIG, 8'h31, ok);
    n = $urandom_range(9, 3);
    for (int i = 0; i < n; i++) begin
      t1_drv <= 1'b1;
      @(posedge core_clk_i);
      t1_drv <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    v = 16'h12fe + 16'(n);
    rd(`SBG_OFF_COUNT, ok, {24'h0, v[7:0]}, '1);
    rd(`SBG_OFF_COUNT_HI, ok, {24'h0, v[15:8]}, '1);
    t1_rand <= 1'b1;
    wr(`SBG_OFF_CONTROL, 8'h00, ok);
    wr(`SBG_OFF_CONFIG, 8'h05, ok);
    wr(`SBG_OFF_RELOAD, 8'hf6, ok);
    wr(`SBG_OFF_COUNT, 8'hf6, ok);
    wr(`SBG_OFF_CONFIG, 8'h07, ok);
    wr(`SBG_OFF_CONFIG, 8'h17, ok);
    gap(2, 20);
    wr(`SBG_OFF_CONFIG, 8'h13, ok);
    gap(2, 240);
    $display("cascade and clock out test done");
    print_verdict;
  end
endmodule
